// file: hdl/lsw_pkg.sv
// Notes on behaviour
// - Enable high starts the turn-on sequence.
// - Select input picks one of two overvoltage levels.
// - Fault flag on overvoltage, power trip, limit, heat.
// - Power-good flag after delay above trigger level.
// - Power above upper threshold turns off at once.
// - Power-limit shutdown retries after fixed delay.
// - Above lower threshold starts blanking, keeps conducting.
// - Still above lower threshold at expiry: off, retry.
// - Power monitoring active in every conducting state.
// - Power is drain-source voltage times current.
// - Overvoltage removes gate drive at once, stays off until it clears.
package lsw_pkg;

  // ===========================================================================
  // Clock and timing.
  localparam int CLK_FREQ_MHZ        = 250;
  localparam int RETRY_DELAY_MS      = 160;
  localparam int BLANK_TIME_MS       = 18;
  localparam int FAULT_DELAY_US      = 10;
  localparam int PG_DELAY_US         = 1000;
  localparam int RETRY_DELAY_CYCLES  = RETRY_DELAY_MS * CLK_FREQ_MHZ * 1000;
  localparam int BLANK_TIME_CYCLES   = BLANK_TIME_MS * CLK_FREQ_MHZ * 1000;
  localparam int FAULT_DELAY_CYCLES  = FAULT_DELAY_US * CLK_FREQ_MHZ;
  localparam int PG_DELAY_CYCLES     = PG_DELAY_US * CLK_FREQ_MHZ;
  localparam int TIMER_W             = 26;

  // ===========================================================================
  // Measurement scaling: voltage codes are 10 mV per step, current 2 mA per step,
  // so one step of the power product is 20 uW.
  localparam int CODE_W              = 12;
  localparam int POWER_W             = 2 * CODE_W;
  localparam logic [POWER_W-1:0] POWER_HIGH_LIMIT = 24'h1312d0;  // 25 W.
  localparam logic [POWER_W-1:0] POWER_LOW_LIMIT  = 24'h098968;  // 12.5 W.
  localparam logic [CODE_W-1:0]  INPUT_OVERVOLTAGE_LOCKOUT_LEVEL_LOW   = 12'h640;     // 16 V.
  localparam logic [CODE_W-1:0]  INPUT_OVERVOLTAGE_LOCKOUT_LEVEL_HIGH  = 12'h8fc;     // 23 V.
  localparam logic [CODE_W-1:0]  POWER_GOOD_LEVEL = 12'h384;     // 9 V.

  // ===========================================================================
  // Types.
  typedef struct packed {
    logic [CODE_W-1:0] vin;   // Input (drain) voltage code.
    logic [CODE_W-1:0] vds;   // Drain-source voltage code.
    logic [CODE_W-1:0] ids;   // Drain-source current code.
    logic [CODE_W-1:0] vout;  // Output (source) voltage code.
  } lsw_sample_t;

  typedef enum logic [2:0] {
    LSW_IDLE    = 3'b000,
    LSW_RAMP    = 3'b001,
    LSW_ON      = 3'b010,
    LSW_RETRY   = 3'b011,
    LSW_OV_LOCK = 3'b100
  } lsw_state_t;

  typedef enum logic [1:0] {
    LSW_TRIP_NONE  = 2'b00,
    LSW_TRIP_HIGH  = 2'b01,
    LSW_TRIP_BLANK = 2'b10
  } lsw_trip_t;

endpackage : lsw_pkg

// file: hdl/lsw_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lsw_delay_timer
  import lsw_pkg::*;
(
  input  wire logic               i_core_clk,  // Core clock.
  input  wire logic               i_reset,     // Synchronous reset, active high.
  input  wire logic               i_run,       // Count while high, else restart.
  input  wire logic [TIMER_W-1:0] i_limit,     // Cycles until done.
  output logic                    o_done       // Level, high once limit reached.
);

  logic [TIMER_W-1:0] count_q;

  // ===========================================================================
  // Count saturates at the limit so done stays high while run stays high.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || !i_run)
    begin
      count_q <= '0;
    end
    else if (count_q < i_limit)
    begin
      count_q <= count_q + 1'b1;
    end
  end

  assign o_done = i_run && (count_q >= i_limit);

endmodule : lsw_delay_timer
`default_nettype wire

// file: hdl/lsw_load_switch_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module lsw_load_switch_fsm
#(
  parameter int RETRY_CYCLES = lsw_pkg::RETRY_DELAY_CYCLES,  // Auto-retry wait.
  parameter int BLANK_CYCLES = lsw_pkg::BLANK_TIME_CYCLES,   // Lower-level blanking.
  parameter int PG_CYCLES    = lsw_pkg::PG_DELAY_CYCLES      // Power-good delay.
)
(
  input  wire logic                i_core_clk,       // Core clock, 250 MHz.
  input  wire logic                i_reset,          // Synchronous reset, active high.
  input  wire logic                i_enable,         // Switch enable from host.
  input  wire logic                i_input_overvoltage_lockout_sel,       // 0 low level, 1 high level.
  input  wire lsw_pkg::lsw_sample_t i_sample,        // Measured voltages and current.
  input  wire logic                i_current_limit,  // Current limiter is active.
  input  wire logic                i_over_temp,      // Over-temperature comparator.
  input  wire logic                i_fault_pin,      // Fault pin level, unused.
  input  wire logic                i_pg_pin,         // Power-good pin level, unused.
  output logic                     o_gate_en,        // Pass-transistor gate drive.
  output logic                     o_fault_out,      // Fault pin drive value.
  output logic                     o_fault_oe,       // Fault pin pulled low.
  output logic                     o_pg_out,         // Power-good pin drive value.
  output logic                     o_pg_oe,          // Power-good pin pulled low.
  output lsw_pkg::lsw_state_t      o_state,          // Sequencer state.
  output lsw_pkg::lsw_trip_t       o_trip_cause,     // Last power-limit trip cause.
  output logic                     o_blanking        // Blanking timer running.
);
  import lsw_pkg::*;

  // ===========================================================================
  // Declarations.
  lsw_state_t          state_q;
  lsw_state_t          state_d;
  lsw_trip_t           trip_q;
  logic                gate_q;
  logic                fault_oe_q;
  logic                pg_oe_q;
  logic                fault_out_q;
  logic                pg_out_q;
  logic                blanking_q;
  logic [POWER_W-1:0]  power;
  logic [CODE_W-1:0]   input_overvoltage_lockout_level;
  logic                over_voltage;
  logic                power_high;
  logic                power_low;
  logic                conducting;
  logic                gate_d;
  logic                blank_run;
  logic                blank_done;
  logic                retry_done;
  logic                fault_cond;
  logic                fault_done;
  logic                vout_good;
  logic                pg_run;
  logic                pg_done;

  // ===========================================================================
  // Comparators.
  assign power        = i_sample.vds * i_sample.ids;
  assign power_high   = power > POWER_HIGH_LIMIT;
  assign power_low    = power > POWER_LOW_LIMIT;
  assign input_overvoltage_lockout_level   = i_input_overvoltage_lockout_sel ? INPUT_OVERVOLTAGE_LOCKOUT_LEVEL_HIGH : INPUT_OVERVOLTAGE_LOCKOUT_LEVEL_LOW;
  assign over_voltage = i_sample.vin > input_overvoltage_lockout_level;
  assign vout_good    = i_sample.vout > POWER_GOOD_LEVEL;

  // The gate is on in both ramp and steady state, so power checks cover both,
  // whether or not the current limiter is active.
  assign conducting = (state_q == LSW_RAMP) || (state_q == LSW_ON);

  // Gate drive and the blanking flag both look one state ahead, so neither of
  // them shows the switch conducting on the edge that trips it.
  assign gate_d     = (state_d == LSW_RAMP) || (state_d == LSW_ON);

  // ===========================================================================
  // Timers.
  // Blanking restarts whenever power drops back under the lower level, so only
  // an uninterrupted overload of the full blanking time trips the switch below the upper level.
  assign blank_run = conducting && power_low && i_enable;

  lsw_delay_timer u_blank_timer (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_run      (blank_run),
    .i_limit    (TIMER_W'(BLANK_CYCLES)),
    .o_done     (blank_done)
  );

  lsw_delay_timer u_retry_timer (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_run      (state_q == LSW_RETRY),
    .i_limit    (TIMER_W'(RETRY_CYCLES)),
    .o_done     (retry_done)
  );

  // A power-limit trip counts as a fault for the whole retry wait.
  assign fault_cond = over_voltage || i_current_limit || i_over_temp
                    || (state_q == LSW_RETRY) || (state_q == LSW_OV_LOCK);

  lsw_delay_timer u_fault_timer (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_run      (fault_cond && i_enable),
    .i_limit    (TIMER_W'(FAULT_DELAY_CYCLES)),
    .o_done     (fault_done)
  );

  assign pg_run = vout_good && gate_q;

  lsw_delay_timer u_pg_timer (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_run      (pg_run),
    .i_limit    (TIMER_W'(PG_CYCLES)),
    .o_done     (pg_done)
  );

  // ===========================================================================
  // Sequencer next state.
  // Priority: enable low, then overvoltage, then upper power level, then the
  // expired blanking window. Shutdown needs no blanking at the upper level.
  always_comb
  begin
    state_d = state_q;
    if (!i_enable)
    begin
      state_d = LSW_IDLE;
    end
    else
    begin
      unique case (state_q)
        LSW_IDLE:
        begin
          if (over_voltage)
          begin
            state_d = LSW_OV_LOCK;
          end
          else
          begin
            state_d = LSW_RAMP;
          end
        end
        LSW_RAMP, LSW_ON:
        begin
          if (over_voltage)
          begin
            state_d = LSW_OV_LOCK;
          end
          else if (power_high)
          begin
            state_d = LSW_RETRY;
          end
          else if (blank_done && power_low)
          begin
            state_d = LSW_RETRY;
          end
          else if (state_q == LSW_RAMP && vout_good)
          begin
            state_d = LSW_ON;
          end
        end
        LSW_RETRY:
        begin
          if (retry_done)
          begin
            state_d = over_voltage ? LSW_OV_LOCK : LSW_RAMP;
          end
        end
        LSW_OV_LOCK:
        begin
          if (!over_voltage)
          begin
            state_d = LSW_RAMP;
          end
        end
        default:
        begin
          state_d = LSW_IDLE;
        end
      endcase
    end
  end

  // ===========================================================================
  // Sequencer state.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state_q <= LSW_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ===========================================================================
  // Gate drive follows the next state, so a trip removes it on the same edge
  // that the sequencer leaves the conducting states.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      gate_q <= 1'b0;
    end
    else
    begin
      gate_q <= gate_d;
    end
  end

  // ===========================================================================
  // Trip cause, kept until the next power-limit trip or enable low.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || !i_enable)
    begin
      trip_q <= LSW_TRIP_NONE;
    end
    else if (conducting && !over_voltage && power_high)
    begin
      trip_q <= LSW_TRIP_HIGH;
    end
    else if (conducting && !over_voltage && blank_done && power_low)
    begin
      trip_q <= LSW_TRIP_BLANK;
    end
  end

  // ===========================================================================
  // Blanking indication.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      blanking_q <= 1'b0;
    end
    else
    begin
      blanking_q <= blank_run && !blank_done && gate_d;
    end
  end

  // ===========================================================================
  // Open-drain flags. Fault pulls low when asserted; power-good is released
  // high when good and pulled low otherwise. Fault releases as soon as every
  // condition has cleared, which after a clean retry returns it high.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      fault_oe_q <= 1'b0;
    end
    else
    begin
      fault_oe_q <= fault_done;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      pg_oe_q <= 1'b1;
    end
    else
    begin
      pg_oe_q <= !pg_done;
    end
  end

  // ===========================================================================
  // Open-drain drive values. Both pins only ever pull low, so the drive value
  // stays zero and the output enables alone decide what the host sees.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      fault_out_q <= 1'b0;
    end
    else
    begin
      fault_out_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      pg_out_q <= 1'b0;
    end
    else
    begin
      pg_out_q <= 1'b0;
    end
  end

  // ===========================================================================
  // Outputs.
  assign o_gate_en    = gate_q;
  assign o_fault_out  = fault_out_q;
  assign o_fault_oe   = fault_oe_q;
  assign o_pg_out     = pg_out_q;
  assign o_pg_oe      = pg_oe_q;
  assign o_state      = state_q;
  assign o_trip_cause = trip_q;
  assign o_blanking   = blanking_q;

endmodule : lsw_load_switch_fsm
`default_nettype wire

// file: verification/lsw_load_switch_fsm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lsw_load_switch_fsm_properties
#(
  parameter int RETRY_CYCLES = 50,  // Retry wait.
  parameter int BLANK_CYCLES = 20,  // Blanking.
  parameter int PG_CYCLES    = 10   // Pg delay.
)
(
  input wire logic                 i_core_clk,       // Clock.
  input wire logic                 i_reset,          // Reset.
  input wire logic                 i_enable,         // Enable.
  input wire logic                 i_input_overvoltage_lockout_sel,       // Level select.
  input wire lsw_pkg::lsw_sample_t i_sample,         // Samples.
  input wire logic                 i_current_limit,  // Limiter.
  input wire logic                 i_over_temp,      // Heat.
  input wire logic                 o_gate_en,        // Gate.
  input wire logic                 o_fault_oe,       // Fault low.
  input wire logic                 o_pg_oe,          // Pg low.
  input wire lsw_pkg::lsw_state_t  o_state,          // State.
  input wire lsw_pkg::lsw_trip_t   o_trip_cause,     // Trip.
  input wire logic                 o_blanking        // Blanking.
);
  import lsw_pkg::*;
  logic [POWER_W-1:0] pw;
  logic               ov;
  logic               run_ok;
  logic               pg_ok;
  int                 retry_q;
  int                 heat_q;
  assign pw = i_sample.vds * i_sample.ids;
  assign ov = i_sample.vin > (i_input_overvoltage_lockout_sel ? INPUT_OVERVOLTAGE_LOCKOUT_LEVEL_HIGH : INPUT_OVERVOLTAGE_LOCKOUT_LEVEL_LOW);
  assign run_ok = i_enable && !ov && (o_state == LSW_RAMP || o_state == LSW_ON);
  assign pg_ok = o_gate_en && i_sample.vout > POWER_GOOD_LEVEL;
  // ===========================================================================
  // Counters of how long a condition has lasted.
  always_ff @(posedge i_core_clk)
  begin
    retry_q <= (!i_reset && o_state == LSW_RETRY) ? retry_q + 1 : 0;
    heat_q  <= (!i_reset && i_over_temp) ? heat_q + 1 : 0;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  chk_enable_starts: assert property (
    i_enable && !ov && o_state == LSW_IDLE |=> o_state == LSW_RAMP && o_gate_en)
    else $error("enable did not start the ramp");
  chk_high_trip: assert property (
    run_ok && pw > POWER_HIGH_LIMIT |=> o_state == LSW_RETRY && !o_gate_en
    && o_trip_cause == LSW_TRIP_HIGH) else $error("upper power level not tripped");
  chk_off_idle: assert property (!i_enable |=>
    o_state == LSW_IDLE && !o_gate_en && !o_blanking) else $error("enable low ignored");
  chk_ov_lock: assert property (
    i_enable && ov && o_state != LSW_RETRY |=> o_state == LSW_OV_LOCK && !o_gate_en)
    else $error("overvoltage did not lock");
  chk_blank_start: assert property ($rose(o_blanking) |->
    o_gate_en && $past(pw) > POWER_LOW_LIMIT) else $error("bad blanking start");
  chk_retry_len: assert property (
    $past(o_state) == LSW_RETRY && o_state == LSW_RAMP |->
    retry_q >= RETRY_CYCLES - 1 && retry_q <= RETRY_CYCLES + 2) else $error("bad retry");
  chk_fault_delay: assert property (
    heat_q > FAULT_DELAY_CYCLES + 4 |-> o_fault_oe) else $error("fault flag late");
  chk_pg_release: assert property (
    !o_pg_oe |-> $past(pg_ok)) else $error("power-good without output");
  cover property (o_state == LSW_RETRY && o_trip_cause == LSW_TRIP_BLANK);
  cover property (!o_pg_oe);
  cover property (o_fault_oe && i_over_temp);
endmodule : lsw_load_switch_fsm_properties
bind lsw_load_switch_fsm lsw_load_switch_fsm_properties #(.RETRY_CYCLES(RETRY_CYCLES),
  .BLANK_CYCLES(BLANK_CYCLES), .PG_CYCLES(PG_CYCLES)) u_props (.i_core_clk(i_core_clk),
  .i_reset(i_reset), .i_enable(i_enable), .i_input_overvoltage_lockout_sel(i_input_overvoltage_lockout_sel), .i_sample(i_sample),
  .i_current_limit(i_current_limit), .i_over_temp(i_over_temp), .o_gate_en(o_gate_en),
  .o_fault_oe(o_fault_oe), .o_pg_oe(o_pg_oe), .o_state(o_state),
  .o_trip_cause(o_trip_cause), .o_blanking(o_blanking));
`default_nettype wire

// file: verification/lsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsw_host_model
(
  input  wire logic i_core_clk,   // Clock.
  input  wire logic i_want_on,    // Switch wanted on.
  input  wire logic i_sel_high,   // High level wanted.
  input  wire logic i_fault_oe,   // Fault pin pulled low.
  input  wire logic i_pg_oe,      // Pg pin pulled low.
  output logic      o_enable,     // Enable, always driven.
  output logic      o_input_overvoltage_lockout_sel,   // Level select.
  output logic      o_fault_pin,  // Fault wire level.
  output logic      o_pg_pin      // Pg wire level.
);
  // The enable has no pull of its own, so the host drives it low from time zero.
  initial
  begin
    o_enable = 1'b0;
    o_input_overvoltage_lockout_sel = 1'b0;
  end
  always @(negedge i_core_clk)
  begin
    o_enable   <= i_want_on;
    o_input_overvoltage_lockout_sel <= i_sel_high;
  end
  // Both flags are open-drain with pull-ups, so a released pin reads high.
  assign o_fault_pin = i_fault_oe ? 1'b0 : 1'b1;
  assign o_pg_pin = i_pg_oe ? 1'b0 : 1'b1;
endmodule : lsw_host_model
`default_nettype wire

// file: verification/load_switch_soa_protection_fsm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module load_switch_soa_protection_fsm_tb;
  import lsw_pkg::*;
  localparam int RC = 50;
  localparam int BC = 20;
  localparam int PC = 10;
  logic        clk, rst, want_on, sel_req, ena, sel, clim, otemp, fpin, ppin;
  logic        gate, foe, poe, blank, fout, pout;
  lsw_sample_t smp;
  lsw_state_t  st;
  lsw_trip_t   trip;
  logic [7:0]  lf = 8'h1a;
  int          n_fail, n_checks, cyc, t;
  int          ids_q[$] = '{12'h5dc, 12'h258};
  lsw_host_model u_host (.i_core_clk(clk), .i_want_on(want_on), .i_sel_high(sel_req),
    .i_fault_oe(foe), .i_pg_oe(poe), .o_enable(ena), .o_input_overvoltage_lockout_sel(sel),
    .o_fault_pin(fpin), .o_pg_pin(ppin));
  lsw_load_switch_fsm #(.RETRY_CYCLES(RC), .BLANK_CYCLES(BC), .PG_CYCLES(PC)) DUT (
    .i_core_clk(clk), .i_reset(rst), .i_enable(ena), .i_input_overvoltage_lockout_sel(sel), .i_sample(smp),
    .i_current_limit(clim), .i_over_temp(otemp), .i_fault_pin(fpin), .i_pg_pin(ppin),
    .o_gate_en(gate), .o_fault_out(fout), .o_fault_oe(foe), .o_pg_out(pout), .o_pg_oe(poe),
    .o_state(st), .o_trip_cause(trip), .o_blanking(blank));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ===========================================================================
  // Reference model and helpers.
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic lsw_trip_t exp_trip(input int p);
    return p > POWER_HIGH_LIMIT ? LSW_TRIP_HIGH
         : p > POWER_LOW_LIMIT ? LSW_TRIP_BLANK : LSW_TRIP_NONE;
  endfunction : exp_trip
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic wait_st(input lsw_state_t s, input int lim);
    t = 0;
    while (st !== s && t < lim)
    begin
      @(negedge clk);
      t++;
    end
    chk("wait_state", st, s);
  endtask : wait_st
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  // ===========================================================================
  // Scenarios.
  initial
  begin
    rst = 1'b1;
    {want_on, sel_req, clim, otemp} = 4'h0;
    smp = '{vin: {4'h0, lf}, vds: 12'h4b0, ids: 12'h010, vout: 12'h4b0};
    step(10);
    rst = 1'b0;
    step(1);
    chk("state", st, LSW_IDLE);
    want_on <= 1'b1;
    step(2);
    chk("state", st, LSW_RAMP);
    chk("gate", gate, 1'b1);
    repeat (PC + 6)
    begin
      lf = lfsr(lf);
      smp.ids = {4'h0, lf};
      step(1);
    end
    chk("pg_pin", ppin, 1'b1);
    chk("drive_low", {fout, pout}, 2'b00);
    chk("fault_oe", foe, 1'b0);
    foreach (ids_q[i])
    begin
      clim = (i == 1);
      smp.ids = ids_q[i][11:0];
      step(1);
      chk("gate", gate, i == 1);
      wait_st(LSW_RETRY, BC + 8);
      chk("trip_wait", i == 0 ? t == 0 : (t >= BC - 3 && t <= BC + 3), 1'b1);
      chk("trip", trip, exp_trip(1200 * ids_q[i]));
      smp.ids = 12'h010;
      clim = 1'b0;
      wait_st(LSW_RAMP, RC + 8);
      chk("retry_wait", t >= RC - 3 && t <= RC + 3, 1'b1);
      chk("gate", gate, 1'b1);
      wait_st(LSW_ON, 10);
      chk("fault_oe", foe, 1'b0);
    end
    smp.vin = 12'h700;
    step(1);
    chk("state", st, 12'h700 > INPUT_OVERVOLTAGE_LOCKOUT_LEVEL_LOW ? LSW_OV_LOCK : LSW_ON);
    chk("gate", gate, 1'b0);
    sel_req <= 1'b1;
    step(2);
    chk("state", st, 12'h700 > INPUT_OVERVOLTAGE_LOCKOUT_LEVEL_HIGH ? LSW_OV_LOCK : LSW_RAMP);
    wait_st(LSW_ON, 10);
    otemp = 1'b1;
    step(FAULT_DELAY_CYCLES + 6);
    chk("fault_pin", fpin, 1'b0);
    chk("gate", gate, 1'b1);
    otemp = 1'b0;
    step(2);
    chk("fault_oe", foe, 1'b0);
    smp.ids = 12'h258;
    step(4);
    chk("blank_gate", {blank, gate}, 2'b11);
    want_on <= 1'b0;
    step(2);
    chk("state", st, LSW_IDLE);
    chk("gate_blank", {gate, blank}, 2'b00);
    smp.ids = 12'h010;
    want_on <= 1'b1;
    step(2);
    chk("state", st, LSW_RAMP);
    results();
  end
endmodule : load_switch_soa_protection_fsm_tb
`default_nettype wire
